//--- sahc_cfg.svh
`ifndef SAHC_CFG_SVH
`define SAHC_CFG_SVH

// Register byte offsets
`define SAHC_CTRL_OFFSET 12'h000
`define SAHC_STATUS_OFFSET 12'h004
`define SAHC_RESULT_OFFSET 12'h008
`define SAHC_CONV_OFFSET 12'h00C

// Control register fields
`define SAHC_CTRL_CE_BIT 0
`define SAHC_CTRL_CS_N_BIT 1
`define SAHC_CTRL_RC_BIT 2
`define SAHC_CTRL_A0_BIT 3
`define SAHC_CTRL_WORD_BIT 4
`define SAHC_CTRL_RESET 32'h0000_0002

// Status register fields
`define SAHC_STAT_BUSY_BIT 0
`define SAHC_STAT_OE_LO_BIT 1
`define SAHC_STAT_OE_MID_BIT 2
`define SAHC_STAT_OE_HI_BIT 3
`define SAHC_STAT_SHORT_BIT 4
`define SAHC_STAT_TRACK_BIT 5

// Timing
`define SAHC_CLK_PERIOD_NS 10
`define SAHC_MIN_CONV_LOW_NS 25
`define SAHC_MIN_CONV_LOW_CYC ((`SAHC_MIN_CONV_LOW_NS + `SAHC_CLK_PERIOD_NS - 1) / `SAHC_CLK_PERIOD_NS)
`define SAHC_THROUGHPUT_NS 8500
`define SAHC_THROUGHPUT_CYC (`SAHC_THROUGHPUT_NS / `SAHC_CLK_PERIOD_NS)
`define SAHC_BIT_DIV 40
`define SAHC_LATCH_CYC 4'h2

`define SAHC_RESULT_RESET 12'h000
`define SAHC_RESULT_WIDTH 12
`define SAHC_SHORT_BITS 8

`endif

//--- sahc_pkg.sv
package sahc_pkg;
  typedef enum logic [1:0] {
    SAHC_RESP_OKAY = 2'h0,
    SAHC_RESP_SLVERR = 2'h2
  } sahc_resp_type;

  // Last member is bit 0 of the control word
  typedef struct packed {
    logic word_width_select;
    logic byte_addr_short_cycle;
    logic read_not_convert;
    logic select_n;
    logic chip_enable;
  } sahc_ctrl_type;

  typedef struct packed {
    logic [11:0] data;
    logic [11:0] oe;
  } sahc_bus_type;
endpackage

//--- sahc_sync.sv
module sahc_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic async_in,
  output logic sync_out
);
  logic stage1_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1_q <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1_q <= async_in;
      sync_out <= stage1_q;
    end
  end
endmodule

//--- sahc_sar.sv
`include "sahc_cfg.svh"

module sahc_sar (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic short_cycle,
  input wire logic comparator,
  output logic [11:0] trial,
  output logic [11:0] result,
  output logic done,
  output logic tracking
);
  import sahc_pkg::*;

  logic [11:0] bitmask_q;
  logic [11:0] trial_q;
  logic [3:0] left_q;
  logic [7:0] div_q;
  logic active_q;
  logic tick;
  logic [11:0] decided;
  logic last_bit;

  // Bit-decision clock enable from the system clock
  assign tick = active_q && (div_q == 8'(`SAHC_BIT_DIV - 1));
  // Keep or drop the trial bit from the comparator
  assign decided = comparator ? trial_q : (trial_q & ~bitmask_q);
  assign last_bit = (left_q == 4'h1);
  assign trial = trial_q;
  assign tracking = !active_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 8'h00;
    end else if (!active_q || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_q <= 1'b0;
      bitmask_q <= 12'h000;
      trial_q <= 12'h000;
      left_q <= 4'h0;
      result <= `SAHC_RESULT_RESET;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !active_q) begin
        active_q <= 1'b1;
        bitmask_q <= 12'h800;
        trial_q <= 12'h800;
        left_q <= short_cycle ? 4'h8 : 4'hC;
      end else if (tick) begin
        trial_q <= decided | (bitmask_q >> 1);
        bitmask_q <= bitmask_q >> 1;
        left_q <= left_q - 4'h1;
        if (last_bit) begin
          active_q <= 1'b0;
          result <= decided & (short_cycle ? 12'hFF0 : 12'hFFF);
          done <= 1'b1;
        end
      end
    end
  end
endmodule

//--- sahc_top.sv
// Function
// - No start and no output while chip_enable low; its rise may start.
// - select_n high blocks all; its fall may start conversion.
// - read_not_convert low needed to start; its fall may start conversion.
// - read_not_convert high needed to read; its rise may begin read.
// - byte_addr_short_cycle high gives 8-bit, low gives 12-bit conversion.
// - Byte read: low selects high byte, high selects low nibble plus zeros.
// - word_width_select high drives all twelve lines, ignoring byte address.
// - word_width_select low drives only the addressed byte.
// - Output enabled only with enable, select low, read high.
// - Convert pulse at least 25ns low; falling edge holds and converts. Low time is not checked: start fires on the falling edge.
// - Busy high during conversion; falls after result latched.
// - Busy high keeps all data lines high impedance.
// - Start transitions ignored while busy; no restart or abort.
// - Tracking resumes as conversion ends, before busy falls.
// - Conversion plus acquisition supports 117kHz sustained rate.
// - Bits tested MSB first; trial applied then latched from comparator.
// - Only byte_addr_short_cycle latched at start; holds length.
// - After 8-bit conversion the four LSBs read zero.
// - Output enabled only when read high, busy low, enable high, select low.
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`include "sahc_cfg.svh"

module sahc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic comparator_in,
  output logic [11:0] trial_value,
  output logic tracking,
  output logic busy,
  output sahc_pkg::sahc_bus_type data_bus_out
);
  import sahc_pkg::*;

  sahc_ctrl_type ctrl_q;
  sahc_ctrl_type ctrl_prev_q;
  logic comp_sync;
  logic [11:0] result;
  logic [11:0] trial;
  logic sar_done;
  logic sar_tracking;
  logic short_q;
  logic short_sel;
  logic busy_q;
  logic [3:0] latch_cnt_q;
  logic [7:0] low_cnt_q;
  logic [9:0] period_cnt_q;
  logic period_ok_q;
  logic aw_held_q;
  logic w_held_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic ar_pending;
  logic do_write;
  logic ce_rise;
  logic cs_fall;
  logic rc_fall;
  logic qualified;
  logic start_evt;
  logic read_en;
  logic [11:0] oe_mask;
  logic [11:0] bus_data;
  logic [11:0] status_word;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;

  function automatic logic addr_mapped(input logic [11:0] addr);
    addr_mapped = (addr == `SAHC_CTRL_OFFSET) || (addr == `SAHC_STATUS_OFFSET) ||
                  (addr == `SAHC_RESULT_OFFSET) || (addr == `SAHC_CONV_OFFSET);
  endfunction

  sahc_sync u_comp_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(comparator_in),
    .sync_out(comp_sync)
  );

  sahc_sar u_sar (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start_evt),
    .short_cycle(short_sel),
    .comparator(comp_sync),
    .trial(trial),
    .result(result),
    .done(sar_done),
    .tracking(sar_tracking)
  );

  // Start qualification: the last of the three inputs to arrive fires the start
  assign qualified = ctrl_q.chip_enable && !ctrl_q.select_n && !ctrl_q.read_not_convert;
  assign ce_rise = ctrl_q.chip_enable && !ctrl_prev_q.chip_enable;
  assign cs_fall = !ctrl_q.select_n && ctrl_prev_q.select_n;
  assign rc_fall = !ctrl_q.read_not_convert && ctrl_prev_q.read_not_convert;
  assign start_evt = qualified && (ce_rise || cs_fall || rc_fall) && !busy_q;
  // The length register loads on the start edge, so the converter takes the live pin then
  assign short_sel = start_evt ? ctrl_q.byte_addr_short_cycle : short_q;

  // Output enable decode
  assign read_en = ctrl_q.chip_enable && !ctrl_q.select_n && ctrl_q.read_not_convert
                   && !busy_q;
  assign oe_mask = !read_en ? 12'h000 :
                   ctrl_q.word_width_select ? 12'hFFF :
                   ctrl_q.byte_addr_short_cycle ? 12'h0FF : 12'hFF0;
  // Low byte carries four LSBs then forced zeros on the lines below
  assign bus_data = (!ctrl_q.word_width_select && ctrl_q.byte_addr_short_cycle) ?
                    {4'h0, result[3:0], 4'h0} : result;

  assign status_word = {5'h00, period_ok_q, sar_tracking, short_q, oe_mask[11], oe_mask[4],
                        oe_mask[0], busy_q};
  assign rd_hit = addr_mapped(s_axi_araddr);
  assign wr_hit = addr_mapped(awaddr_q);
  assign rd_word = (s_axi_araddr == `SAHC_CTRL_OFFSET) ? {16'h0, low_cnt_q, 3'h0, ctrl_q} :
                   (s_axi_araddr == `SAHC_STATUS_OFFSET) ? {20'h0, status_word} :
                   (s_axi_araddr == `SAHC_RESULT_OFFSET) ? {20'h0, data_bus_out.data} :
                   (s_axi_araddr == `SAHC_CONV_OFFSET) ? {22'h0, period_cnt_q} : 32'h0;

  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  assign ar_pending = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign trial_value = trial;
  assign tracking = sar_tracking;
  assign busy = busy_q;

  // Write address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SAHC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? SAHC_RESP_OKAY : SAHC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= SAHC_RESP_OKAY;
    end else if (ar_pending) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? SAHC_RESP_OKAY : SAHC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Control pins driven by software through the control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= sahc_ctrl_type'(5'(`SAHC_CTRL_RESET));
      ctrl_prev_q <= sahc_ctrl_type'(5'(`SAHC_CTRL_RESET));
    end else begin
      ctrl_prev_q <= ctrl_q;
      if (do_write && awaddr_q == `SAHC_CTRL_OFFSET && wstrb_q[0]) begin
        ctrl_q <= wdata_q[4:0];
      end
    end
  end

  // Convert-line low time in cycles, shown in the control readback
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt_q <= 8'h00;
    end else if (ctrl_q.read_not_convert) begin
      low_cnt_q <= 8'h00;
    end else if (low_cnt_q != 8'hFF) begin
      low_cnt_q <= low_cnt_q + 8'h01;
    end
  end

  // Length latched at the start event only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      short_q <= 1'b0;
    end else if (start_evt) begin
      short_q <= ctrl_q.byte_addr_short_cycle;
    end
  end

  // Busy spans the conversion and the latch settle after the last decision
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'b0;
      latch_cnt_q <= 4'h0;
    end else if (start_evt) begin
      busy_q <= 1'b1;
      latch_cnt_q <= 4'h0;
    end else if (sar_done) begin
      latch_cnt_q <= `SAHC_LATCH_CYC;
    end else if (latch_cnt_q == 4'h1) begin
      busy_q <= 1'b0;
      latch_cnt_q <= 4'h0;
    end else if (latch_cnt_q != 4'h0) begin
      latch_cnt_q <= latch_cnt_q - 4'h1;
    end
  end

  // Throughput monitor: cycles from one start to the next
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_cnt_q <= 10'h000;
      period_ok_q <= 1'b1;
    end else if (start_evt) begin
      period_cnt_q <= 10'h000;
    end else if (period_cnt_q != 10'h3FF) begin
      period_cnt_q <= period_cnt_q + 10'h001;
      if (busy_q && period_cnt_q == 10'(`SAHC_THROUGHPUT_CYC)) begin
        period_ok_q <= 1'b0;
      end
    end
  end

  // Data outputs registered from the decode above
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_bus_out <= '0;
    end else begin
      data_bus_out.oe <= oe_mask;
      data_bus_out.data <= bus_data;
    end
  end
endmodule

//--- sahc_properties.sv
module sahc_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] trial_value,
  input wire logic tracking,
  input wire logic busy,
  input wire sahc_pkg::sahc_bus_type data_bus_out
);
  import sahc_pkg::*;
  logic [9:0] cnt_q;
  logic [9:0] cnt_d;
  // Busy cycles so far in the current conversion
  assign cnt_d = busy ? cnt_q + 10'h001 : 10'h000;
  always_ff @(posedge aclk) cnt_q <= aresetn ? cnt_d : 10'h000;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  hiz_busy_a: assert property (busy |-> data_bus_out.oe == 12'h000)
    else $error("lines driven while busy");
  oe_shape_a: assert property (data_bus_out.oe inside {12'h000, 12'hFFF, 12'hFF0, 12'h0FF})
    else $error("bad output enable pattern");
  low_byte_a: assert property (data_bus_out.oe == 12'h0FF |-> data_bus_out.data[3:0] == 4'h0)
    else $error("low byte trailing bits not zero");
  no_abort_a: assert property ($rose(busy) |-> busy [*8])
    else $error("conversion cut short");
  busy_len_a: assert property ($fell(busy) |-> cnt_q >= 10'd300 && cnt_q <= 10'd520)
    else $error("conversion length out of range");
  busy_cap_a: assert property (busy |-> cnt_q < 10'd600)
    else $error("conversion too slow");
  track_done_a: assert property ($fell(busy) |-> tracking)
    else $error("not tracking when busy falls");
  hold_start_a: assert property ($rose(busy) |-> ##[0:2] !tracking)
    else $error("input not held at start");
  msb_first_a: assert property ($rose(busy) |-> ##[0:3] trial_value == 12'h800)
    else $error("first trial is not the top bit");
  cover property ($fell(busy));
  cover property (data_bus_out.oe == 12'hFFF);
  cover property (data_bus_out.oe == 12'hFF0);
  cover property (data_bus_out.oe == 12'h0FF);
endmodule
bind sahc_top sahc_props u_props (.aclk(aclk), .aresetn(aresetn), .trial_value(trial_value),
  .tracking(tracking), .busy(busy), .data_bus_out(data_bus_out));

//--- sahc_analog_model.sv
module sahc_analog_model (
  input wire logic aclk,
  input wire logic [11:0] trial_value,
  input wire logic tracking,
  input wire logic [11:0] vin,
  output logic comparator_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] held_q = 12'h000;
  // Sampler follows the input while tracking and freezes it otherwise
  always @(posedge aclk) if (tracking) held_q <= vin;
  // High keeps the trial bit
  assign comparator_in = trial_value <= held_q;
endmodule

//--- sar_adc_host_control_tb_top.sv
module sar_adc_host_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sahc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000, vin = 12'h000, trial_value;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic comparator_in, tracking, busy;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  sahc_bus_type data_bus_out;
  int n_fail = 0, n_compared = 0, cyc = 0;
  `define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    $display("unexpected %s exp %h got %h", nm, e, g); n_fail++; end end
  sahc_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .comparator_in, .trial_value, .tracking, .busy, .data_bus_out);
  sahc_analog_model PM (.aclk, .trial_value, .tracking, .vin, .comparator_in);
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rdchk(input logic [31:0] c, input logic [11:0] eo, input logic [11:0] ed);
    wr(12'h000, c);
    repeat (3) @(posedge aclk);
    `CHK("oe", eo, data_bus_out.oe)
    `CHK("data", ed & eo, data_bus_out.data & eo)
  endtask
  task automatic nostart;
    logic [31:0] seq [4] = '{32'h2, 32'h3, 32'h16, 32'h14};
    foreach (seq[i]) begin
      wr(12'h000, seq[i]);
      repeat (3) @(posedge aclk);
      `CHK("busy", 1'b0, busy)
      `CHK("oe", 12'h000, data_bus_out.oe)
    end
    $display("no-start cases done");
  endtask
  task automatic conv(input logic [31:0] pre, input logic a0, input logic [11:0] v);
    logic [11:0] r;
    logic [31:0] d;
    logic [1:0] rs;
    int n;
    r = a0 ? (v & 12'hFF0) : v;
    n = 0;
    vin <= v;
    wr(12'h000, pre | {a0, 3'b000});
    wr(12'h000, 32'h1 | {a0, 3'b000});
    repeat (2) @(posedge aclk);
    `CHK("busy", 1'b1, busy)
    rd(12'h004, d, rs);
    `CHK("status", {1'b1, 1'b0, a0, 4'h1}, d[6:0])
    wr(12'h000, {~a0, 3'b101});
    wr(12'h000, {~a0, 3'b001});
    while (busy) begin
      @(posedge aclk);
      n++;
    end
    `CHK("long", ~a0, n > 380)
    rdchk(32'h1D, 12'hFFF, r);
    rd(12'h008, d, rs);
    `CHK("result", r, d[11:0])
    rdchk(32'h5, 12'hFF0, r);
    rdchk(32'hD, 12'h0FF, {4'h0, r[3:0], 4'h0});
    $display("conversion of %h done", v);
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] rs;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    nostart();
    conv(32'h5, 1'b0, 12'hA5C);
    conv(32'h0, 1'b1, 12'h3E7);
    conv(32'h3, 1'b0, 12'h801);
    rd(12'h010, d, rs);
    `CHK("unmapped", 2'h2, rs)
    $display("unmapped read done");
    tally_and_finish();
  end
endmodule
